// ==== hdl/sps_sram_core.sv ====
// Purpose: Split port burst-of-two SRAM core with a dual-clock write queue and DDR read outputs.
// Assumes: Output clock is frequency locked to the link clock with bounded skew, as on the board.
// Notes:   The array is a dual-clock memory: written on clock_i, read on the link clock.
`timescale 1ns/1ps
`default_nettype none

module sps_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wbin_q, wbin_d, wgray_q, rbin_q, rbin_d, rgray_q;
  logic [AW:0]      rgray_m_q, rgray_s_q, wgray_m_q, wgray_s_q;
  logic             push, pop;

  // Full when the write pointer has lapped the synchronised read pointer
  assign in_ready_o  = (wgray_q != {~rgray_s_q[AW:AW-1], rgray_s_q[AW-2:0]});
  assign out_valid_o = (rgray_q != wgray_s_q);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = store[rbin_q[AW-1:0]];

  always_comb
  begin
    wbin_d = wbin_q + {{AW{1'b0}}, push};
    rbin_d = rbin_q + {{AW{1'b0}}, pop};
  end

  always_ff @(posedge wr_clk_i)
  begin
    if (push)
    begin
      store[wbin_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge wr_clk_i)
  begin
    if (wr_rst_i)
    begin
      wbin_q    <= '0;
      wgray_q   <= '0;
      rgray_m_q <= '0;
      rgray_s_q <= '0;
    end
    else
    begin
      wbin_q    <= wbin_d;
      wgray_q   <= bin2gray(wbin_d);
      rgray_m_q <= rgray_q;
      rgray_s_q <= rgray_m_q;
    end
  end

  always_ff @(posedge rd_clk_i)
  begin
    if (rd_rst_i)
    begin
      rbin_q    <= '0;
      rgray_q   <= '0;
      wgray_m_q <= '0;
      wgray_s_q <= '0;
    end
    else
    begin
      rbin_q    <= rbin_d;
      rgray_q   <= bin2gray(rbin_d);
      wgray_m_q <= wgray_q;
      wgray_s_q <= wgray_m_q;
    end
  end

endmodule

module sps_sram_core
  import sps_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       link_k_i,
  input  wire logic                       out_c_i,
  input  wire logic                       single_clk_mode_i,
  input  wire logic [sps_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                       read_port_select_n_i,
  input  wire logic                       write_port_select_n_i,
  input  wire logic [sps_pkg::WORD_W-1:0] wr_data_i,
  input  wire logic                       lower_byte_write_en_n_i,
  input  wire logic                       upper_byte_write_en_n_i,
  output logic [sps_pkg::WORD_W-1:0]      rd_data_o,
  output logic                            rd_data_oe_o,
  output logic                            wr_ready_o
);
  import sps_pkg::*;

  // Array: each location holds a two-word burst split into four byte lanes
  logic [LANES-1:0][LANE_W-1:0] mem [MEM_DEPTH];

  // Link domain reset, caught from rst_i
  logic rst_k_m_q, rst_k_q;
  always_ff @(posedge link_k_i)
  begin
    rst_k_m_q <= rst_i;
    rst_k_q   <= rst_k_m_q;
  end

  // Read port, positive input clock
  logic              rd_go_q, rd_go_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic              rd_vld_q, rd_vld_d;
  sps_rd_pair_t      rd_pair_q;

  always_comb
  begin
    rd_go_d   = ~read_port_select_n_i;
    rd_addr_d = read_port_select_n_i ? rd_addr_q : addr_i;
    rd_vld_d  = rd_go_q;
  end

  always_ff @(posedge link_k_i)
  begin
    if (rst_k_q)
    begin
      rd_go_q   <= 1'b0;
      rd_addr_q <= '0;
      rd_vld_q  <= 1'b0;
    end
    else
    begin
      rd_go_q   <= rd_go_d;
      rd_addr_q <= rd_addr_d;
      rd_vld_q  <= rd_vld_d;
    end
  end

  // Both words of the location are fetched together
  always_ff @(posedge link_k_i)
  begin
    if (rd_go_q)
    begin
      rd_pair_q <= {mem[rd_addr_q][3], mem[rd_addr_q][2],
                    mem[rd_addr_q][1], mem[rd_addr_q][0]};
    end
  end

  // Write port: first word and select on the positive edge
  logic              wr_go_q, wr_go_d;
  logic [WORD_W-1:0] w0_q, w0_d;
  logic [1:0]        be0_q, be0_d;

  always_comb
  begin
    wr_go_d = ~write_port_select_n_i;
    w0_d    = wr_data_i;
    be0_d   = {~upper_byte_write_en_n_i, ~lower_byte_write_en_n_i};
  end

  always_ff @(posedge link_k_i)
  begin
    if (rst_k_q)
    begin
      wr_go_q <= 1'b0;
      w0_q    <= '0;
      be0_q   <= '0;
    end
    else
    begin
      wr_go_q <= wr_go_d;
      w0_q    <= w0_d;
      be0_q   <= be0_d;
    end
  end

  // Write port: address, second word and its enables on the negative edge
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [WORD_W-1:0] w1_q, w1_d;
  logic [1:0]        be1_q, be1_d;

  always_comb
  begin
    wr_addr_d = addr_i;
    w1_d      = wr_data_i;
    be1_d     = {~upper_byte_write_en_n_i, ~lower_byte_write_en_n_i};
  end

  always_ff @(negedge link_k_i)
  begin
    wr_addr_q <= wr_addr_d;
    w1_q      <= w1_d;
    be1_q     <= be1_d;
  end

  // Completed write burst is queued toward the core clock on the next positive edge
  sps_wr_rec_t rec_in, rec_out;
  logic        fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic        wr_ready_q, wr_ready_d;

  always_comb
  begin
    rec_in.addr = wr_addr_q;
    rec_in.data = {w1_q[WORD_W-1:LANE_W], w1_q[LANE_W-1:0],
                   w0_q[WORD_W-1:LANE_W], w0_q[LANE_W-1:0]};
    rec_in.be   = {be1_q, be0_q};
    wr_ready_d  = fifo_in_ready;
  end

  always_ff @(posedge link_k_i)
  begin
    if (rst_k_q)
    begin
      wr_ready_q <= 1'b0;
    end
    else
    begin
      wr_ready_q <= wr_ready_d;
    end
  end

  sps_async_fifo #(
    .WIDTH (REC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .wr_clk_i    (link_k_i),
    .wr_rst_i    (rst_k_q),
    .in_valid_i  (wr_go_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rec_in),
    .rd_clk_i    (clock_i),
    .rd_rst_i    (rst_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (rec_out)
  );

  // Self-timed array update on the core clock
  sps_wstate_t wstate_q, wstate_d;
  sps_wr_rec_t commit_q, commit_d;

  always_comb
  begin
    wstate_d       = wstate_q;
    commit_d       = commit_q;
    fifo_out_ready = 1'b0;
    unique case (wstate_q)
      SPS_W_IDLE:
      begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid)
        begin
          commit_d = rec_out;
          wstate_d = SPS_W_COMMIT;
        end
      end
      SPS_W_COMMIT:
      begin
        wstate_d = SPS_W_IDLE;
      end
      default:
      begin
        wstate_d = SPS_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wstate_q <= SPS_W_IDLE;
      commit_q <= '0;
    end
    else
    begin
      wstate_q <= wstate_d;
      commit_q <= commit_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (wstate_q == SPS_W_COMMIT)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (commit_q.be[i])
        begin
          mem[commit_q.addr][i] <= commit_q.data[i];
        end
      end
    end
  end

  // Output side: C pair, or K pair in single clock mode (static strap)
  logic oclk;
  assign oclk = single_clk_mode_i ? link_k_i : out_c_i;

  logic              rst_o_m_q, rst_o_q;
  logic              oe_q, oe_d;
  logic [WORD_W-1:0] qhi_q, qhi_d, qlo_q, qlo_d, qnx_q, qnx_d;

  always_ff @(posedge oclk)
  begin
    rst_o_m_q <= rst_i;
    rst_o_q   <= rst_o_m_q;
  end

  always_comb
  begin
    oe_d  = rd_vld_q;
    qhi_d = rd_pair_q.word0;
    // Second word held from the rise, so a back-to-back fetch cannot replace it
    qnx_d = rd_pair_q.word1;
    qlo_d = qnx_q;
  end

  always_ff @(posedge oclk)
  begin
    if (rst_o_q)
    begin
      oe_q  <= 1'b0;
      qhi_q <= '0;
      qnx_q <= '0;
    end
    else
    begin
      oe_q  <= oe_d;
      qhi_q <= qhi_d;
      qnx_q <= qnx_d;
    end
  end

  always_ff @(negedge oclk)
  begin
    qlo_q <= qlo_d;
  end

  // DDR output cell: first word while the clock is high, second while low
  assign rd_data_o    = oclk ? qhi_q : qlo_q;
  assign rd_data_oe_o = oe_q;
  assign wr_ready_o   = wr_ready_q;

endmodule

`default_nettype wire

// ==== include/sps_pkg.sv ====
// Purpose: Shared constants, records and states for the split port burst-of-two SRAM core.
// Assumes: Link clock rising edge stands for the positive input clock, its falling edge for the
//          negative input clock; the same holds for the output clock pair.
// Notes:   Functional notes below.
// Functional notes
// - The array has a read port with its own outputs and a write port with its own inputs sharing one address bus.
// - The read address is captured on the rising edge of the positive input clock and must be valid there.
// - The write address is captured from the shared bus on the rising edge of the negative input clock.
// - Reads and writes proceed independently and may overlap without any bus turnaround.
// - Every access starts only on a positive input clock rising edge where its port select is sampled.
// - Write data arrives at double rate, one word on each positive and one on each negative input clock edge.
// - Read data leaves at double rate on the output clock pair, or on the input clock pair in single clock mode.
// - Each location holds two 18-bit words and every access moves both as a sequential two-word burst.
// - Read and write ports each have their own active-low select so each can be deselected alone.
// - All synchronous inputs are registered by the input clocks and all read data by the output clocks.
// - A captured write is finished by internal self-timed logic with no further timing from the controller.
// - The device decodes a 19-bit address that reaches every location.
// - When the read select is deasserted the pending read completes and the outputs float after the next positive edge.
// - Active-low lower and upper byte enables gate bits 8:0 and 17:9 of each word; disabled bytes stay unchanged.
`default_nettype none
package sps_pkg;

  localparam int ADDR_W     = 19;
  localparam int WORD_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int MEM_DEPTH  = 1 << ADDR_W;

  // Lane order: 0 first word low, 1 first word high, 2 second word low, 3 second word high
  typedef struct packed {
    logic [ADDR_W-1:0]             addr;
    logic [LANES-1:0][LANE_W-1:0]  data;
    logic [LANES-1:0]              be;
  } sps_wr_rec_t;

  localparam int REC_W = $bits(sps_wr_rec_t);

  typedef struct packed {
    logic [WORD_W-1:0] word1;
    logic [WORD_W-1:0] word0;
  } sps_rd_pair_t;

  typedef enum logic [1:0] {
    SPS_W_IDLE   = 2'h1,
    SPS_W_COMMIT = 2'h2
  } sps_wstate_t;

endpackage
`default_nettype wire

// ==== verification/sps_core_sva.sv ====
// Purpose: Port checks for the split port SRAM core.
// Assumes: Read timing is checked in single clock mode.
// Notes:   Bound to every core instance.
`timescale 1ns/1ps
`default_nettype none
module sps_core_sva (
  input wire logic link_k_i,
  input wire logic rst_i,
  input wire logic single_clk_mode_i,
  input wire logic read_port_select_n_i,
  input wire logic rd_data_oe_o,
  input wire logic wr_ready_o
);
  default clocking @(posedge link_k_i); endclocking
  default disable iff (rst_i);
  sequence lone_rd_s;
    single_clk_mode_i && read_port_select_n_i ##1 !read_port_select_n_i
      ##1 read_port_select_n_i [*2];
  endsequence
  sequence two_rd_s;
    single_clk_mode_i && !read_port_select_n_i ##1 !read_port_select_n_i;
  endsequence
  rd_issue_a: assert property (single_clk_mode_i && !read_port_select_n_i |-> ##3 rd_data_oe_o)
    else $error("read gave no output enable");
  rd_idle_a: assert property (single_clk_mode_i && $past(read_port_select_n_i, 3)
    |-> !rd_data_oe_o) else $error("outputs driven without a read");
  oe_start_a: assert property ($rose(rd_data_oe_o) |-> !$past(read_port_select_n_i, 3))
    else $error("output enable rose at wrong time");
  oe_burst_a: assert property (lone_rd_s |=> rd_data_oe_o ##1 !rd_data_oe_o)
    else $error("single read burst length wrong");
  oe_stream_a: assert property (two_rd_s |-> ##2 rd_data_oe_o [*2])
    else $error("back to back reads broke output");
  ready_rise_a: assert property ($fell(rst_i) |-> ##[0:4] wr_ready_o)
    else $error("write ready late after reset");
  ready_hold_a: assert property ($past(wr_ready_o) |-> wr_ready_o)
    else $error("write queue refused");
  rst_quiet_a: assert property (@(posedge link_k_i) disable iff (1'b0)
    rst_i [*8] |-> !wr_ready_o && !rd_data_oe_o) else $error("outputs active in reset");
endmodule
bind sps_sram_core sps_core_sva sps_core_sva_i (.link_k_i, .rst_i, .single_clk_mode_i,
  .read_port_select_n_i, .rd_data_oe_o, .wr_ready_o);
`default_nettype wire

// ==== verification/sps_ctrl_model.sv ====
// Purpose: Controller side clock source for the SRAM core.
// Assumes: Output clock locked to the link clock in phase.
// Notes:   Both clocks run free, as board clocks do.
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl_model #(
  parameter realtime HALF = 15.0
) (
  output logic link_k_o,
  output logic out_c_o
);
  initial
  begin
    link_k_o = 1'b0;
    #7.3;
    forever
    begin
      #HALF link_k_o = ~link_k_o;
    end
  end
  assign out_c_o = link_k_o;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the split port SRAM core.
// Assumes: Single clock mode strapped high, then low just before the second reset.
// Notes:   Read expectations ride a three-stage pipe.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sps_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [WORD_W-1:0] w0, w1;
    logic [3:0]        ben;
    logic [WORD_W-1:0] e0, e1;
  } sps_row_t;
  logic                   clock_i = 1'b0, rst_i = 1'b1, k, c, oe, rdy, smode = 1'b1;
  logic                   rps_n = 1'b1, wps_n = 1'b1, lbe_n = 1'b1, ube_n = 1'b1;
  logic [ADDR_W-1:0]      addr = '0;
  logic [WORD_W-1:0]      wd = '0, q;
  logic [2:0]             pv = '0;
  logic [2:0][WORD_W-1:0] pe0 = '0, pe1 = '0;
  int                     failures = 0, n_tests = 0, cycles = 0;
  sps_row_t idle_r = '{19'h00000, 18'h2AAAA, 18'h15555, 4'hF, 18'h00000, 18'h00000};
  sps_row_t rows [6] = '{
    '{19'h00000, 18'h12345, 18'h2ABCD, 4'h0, 18'h12345, 18'h2ABCD},
    '{19'h7FFFF, 18'h3FFFF, 18'h00000, 4'h0, 18'h3FFFF, 18'h00000},
    '{19'h00001, 18'h0AAAA, 18'h15555, 4'h0, 18'h0AAAA, 18'h15555},
    '{19'h00001, 18'h3FFFF, 18'h3FFFF, 4'hA, 18'h0ABFF, 18'h155FF},
    '{19'h00001, 18'h00000, 18'h00000, 4'h5, 18'h001FF, 18'h001FF},
    '{19'h00001, 18'h3FFFF, 18'h3FFFF, 4'hF, 18'h001FF, 18'h001FF}};
  sps_ctrl_model sps_ctrl_model_i (.link_k_o(k), .out_c_o(c));
  sps_sram_core sps_sram_core_i (.clock_i, .rst_i, .link_k_i(k), .out_c_i(c),
    .single_clk_mode_i(smode), .addr_i(addr), .read_port_select_n_i(rps_n),
    .write_port_select_n_i(wps_n), .wr_data_i(wd), .lower_byte_write_en_n_i(lbe_n),
    .upper_byte_write_en_n_i(ube_n), .rd_data_o(q), .rd_data_oe_o(oe), .wr_ready_o(rdy));
  initial
  begin
    forever
    begin
      #2 clock_i = ~clock_i;
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One link cycle: read request at the rise, write address and second word at the fall
  task automatic cyc(input logic rd, input logic [ADDR_W-1:0] ra, input logic [WORD_W-1:0] e0,
    input logic [WORD_W-1:0] e1, input logic wr, input sps_row_t r);
    @(negedge k);
    #1;
    if (pv[2]) chk("word1", pe1[2], q);
    addr = ra;
    rps_n = !rd;
    wps_n = !wr;
    wd = wr ? r.w0 : ~wd;
    {ube_n, lbe_n} = r.ben[1:0];
    @(posedge k);
    #1;
    pv = {pv[1:0], rd};
    pe0 = {pe0[1:0], e0};
    pe1 = {pe1[1:0], e1};
    chk("enable", WORD_W'(pv[2]), WORD_W'(oe));
    if (pv[2]) chk("word0", pe0[2], q);
    addr = r.a;
    wd = wr ? r.w1 : ~wd;
    {ube_n, lbe_n} = r.ben[3:2];
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 19'h00000, 18'h00000, 18'h00000, 1'b0, idle_r);
  endtask
  task automatic do_reset;
    @(posedge clock_i);
    #1 rst_i = 1'b1;
    repeat (20) @(posedge k);
    #1;
    chk("ready in reset", 18'h00000, WORD_W'(rdy));
    chk("enable in reset", 18'h00000, WORD_W'(oe));
    @(posedge clock_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge k);
    chk("ready", 18'h00001, WORD_W'(rdy));
  endtask
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      cyc(1'b0, 19'h00000, 18'h00000, 18'h00000, 1'b1, rows[i]);
      idle(2);
      cyc(1'b1, rows[i].a, rows[i].e0, rows[i].e1, 1'b0, idle_r);
      idle(2);
      $display("row %0d done", i);
    end
    // Read and write in one cycle, then a read beside a deselected write
    cyc(1'b1, 19'h00000, 18'h12345, 18'h2ABCD, 1'b1,
      '{19'h00002, 18'h01234, 18'h3CDEF, 4'h0, 18'h00000, 18'h00000});
    cyc(1'b1, 19'h7FFFF, 18'h3FFFF, 18'h00000, 1'b0,
      '{19'h00000, 18'h3FFFF, 18'h3FFFF, 4'h0, 18'h00000, 18'h00000});
    idle(2);
    cyc(1'b1, 19'h00002, 18'h01234, 18'h3CDEF, 1'b0, idle_r);
    cyc(1'b1, 19'h00000, 18'h12345, 18'h2ABCD, 1'b0, idle_r);
    idle(3);
    $display("concurrent tests done");
    // Output clock pair takes over the read data from this reset on
    smode = 1'b0;
    do_reset();
    $display("second reset done");
    cyc(1'b1, 19'h00002, 18'h01234, 18'h3CDEF, 1'b0, idle_r);
    idle(3);
    $display("output clock test done");
    summarize();
  end
endmodule
`default_nettype wire
